// ===== sim/cpu_register_file_data_space_tb_top.sv
// self-checking bench for the cpu storage and addressing core
`default_nettype none
module cpu_register_file_data_space_tb_top import cpu_store_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, cmd_valid, busy, done, instr_valid, irq_ack, got, seen, bz;
  cmd_s cmd, c;
  logic [7:0] irq_req, rdata, ext_rdata, v, p, en, rdv;
  logic [11:0] pm_addr, pa;
  logic [15:0] pm_data, instr, ea;
  logic [2:0] irq_vec;
  ext_bus_s ext;
  int bad_count, total_checks, lat, strobes, s0, pen;
  addr_mode_e modes [4] = '{AM_PLAIN, AM_DISP, AM_PREDEC, AM_POSTINC};
  logic [15:0] eas [4] = '{16'h0100, 16'h0105, 16'h00ff, 16'h0100};
  logic [7:0] ylo [4] = '{8'h00, 8'h00, 8'hff, 8'h01};
  logic [15:0] spots [4];
  alu_op_e ops [5] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR};

  cpu_store_core cpu_store_core_inst (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .irq_req(irq_req), .busy(busy), .done(done), .rdata(rdata), .pm_addr(pm_addr), .pm_data(pm_data),
    .instr(instr), .instr_valid(instr_valid), .ext(ext), .ext_rdata(ext_rdata), .irq_ack(irq_ack),
    .irq_vec(irq_vec));
  ext_sram_model ext_sram_model_inst (.clk(clk), .ext(ext), .ext_rdata(ext_rdata));

  // clock and program memory contents
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] pm_word(input logic [11:0] a);
    return {a ^ 12'hc3a, 4'h9};
  endfunction
  assign pm_data = pm_word(pm_addr);
  // count cycles with any external strobe low
  always @(posedge clk) begin
    if (ext.rd_n === 1'b0 || ext.wr_n === 1'b0) strobes <= strobes + 1;
  end

  // expected alu result and winning interrupt index
  function automatic logic [7:0] alu_exp(input alu_op_e o, input logic [7:0] a, input logic [7:0] b);
    case (o)
      OP_ADD: return a + b;
      OP_SUB: return a - b;
      OP_AND: return a & b;
      OP_OR: return a | b;
      default: return a ^ b;
    endcase
  endfunction
  function automatic logic [2:0] lowest(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) if (m[i]) r = i[2:0];
    return r;
  endfunction
  function automatic cmd_s mk(input cmd_kind_e k, input logic [4:0] rd, input logic [4:0] rr,
      input logic [7:0] imm, input logic [15:0] a);
    cmd_s r;
    r = '0;
    r.kind = k;
    r.rd = rd;
    r.rr = rr;
    r.imm = imm;
    r.addr = a;
    r.mode = AM_DIRECT;
    return r;
  endfunction

  // comparison, verdict and request tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen_v);
    total_checks++;
    if (seen_v !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen_v);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic run(input cmd_s q);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= q;
    lat = 0;
    got = 1'b0;
    // the first edge takes the request; done may already stand right after it
    while (!got && lat < 20) begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      lat++;
      if (lat == 1) bz = busy;
      if (done === 1'b1) begin
        got = 1'b1;
        rdv = rdata;
      end
    end
    if (!got) chk("done", 16'h0001, 16'h0000);
  endtask
  task automatic load_immediate_op(input logic [4:0] r, input logic [7:0] d);
    run(mk(LOAD_IMMEDIATE_OP, r, 5'h00, d, 16'h0000));
  endtask
  task automatic st(input logic [15:0] a, input logic [7:0] d);
    load_immediate_op(5'h10, d);
    run(mk(STORE_OP, 5'h00, 5'h10, 8'h00, a));
  endtask
  task automatic ld(input logic [15:0] a);
    run(mk(LOAD_OP, 5'h11, 5'h00, 8'h00, a));
  endtask

  // watchdog
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    irq_req = 8'h00;
    bad_count = 0;
    total_checks = 0;
    strobes = 0;
    void'($urandom(40577));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("rd_n idle", 16'h0001, {15'h0, ext.rd_n});
    chk("wr_n idle", 16'h0001, {15'h0, ext.wr_n});
    // fetch runs one word ahead, pc steps by one
    @(posedge clk);
    #1;
    repeat (4) begin
      pa = pm_addr;
      @(posedge clk);
      #1;
      chk("pm_addr", {4'h0, pa + 12'h001}, {4'h0, pm_addr});
      chk("instr", pm_word(pa), instr);
      chk("instr_valid", 16'h0001, {15'h0, instr_valid});
    end
    // register, i/o and internal sram places through data space
    spots = '{16'($urandom_range(15, 0)), 16'h0025, 16'h0060, 16'h025f};
    foreach (spots[i]) begin
      v = 8'($urandom);
      s0 = strobes;
      st(spots[i], v);
      ld(spots[i]);
      chk("ld data", {8'h0, v}, {8'h0, rdv});
      chk("ld lat", 16'h0001, 16'(lat));
      chk("strobes", 16'(s0), 16'(strobes));
    end
    // alu register and immediate forms
    foreach (ops[i]) begin
      v = 8'($urandom);
      p = 8'($urandom);
      load_immediate_op(5'h12, v);
      load_immediate_op(5'h13, p);
      c = mk(ALU_OP, 5'h12, 5'h13, 8'h00, 16'h0000);
      c.op = ops[i];
      run(c);
      chk("alu rr", {8'h0, alu_exp(ops[i], v, p)}, {8'h0, rdv});
      load_immediate_op(5'h12, v);
      c.use_imm = 1'b1;
      c.imm = p;
      run(c);
      chk("alu imm", {8'h0, alu_exp(ops[i], v, p)}, {8'h0, rdv});
    end
    // y pointer in every indirect mode
    foreach (modes[i]) begin
      load_immediate_op(5'h1c, 8'h00);
      load_immediate_op(5'h1d, 8'h01);
      v = 8'($urandom);
      st(eas[i], v);
      c = mk(LOAD_OP, 5'h11, 5'h00, 8'h00, 16'h0000);
      c.ptr = PS_Y;
      c.mode = modes[i];
      c.disp = 6'h05;
      run(c);
      chk("ptr ld", {8'h0, v}, {8'h0, rdv});
      ld(16'h001c);
      chk("y low", {8'h0, ylo[i]}, {8'h0, rdv});
    end
    // x pointer indexing a register
    load_immediate_op(5'h1a, 8'h03);
    load_immediate_op(5'h1b, 8'h00);
    v = 8'($urandom);
    st(16'h0003, v);
    c = mk(LOAD_OP, 5'h11, 5'h00, 8'h00, 16'h0000);
    c.mode = AM_PLAIN;
    run(c);
    chk("x to reg", {8'h0, v}, {8'h0, rdv});
    // table byte through z
    load_immediate_op(5'h1e, 8'h13);
    load_immediate_op(5'h1f, 8'h00);
    run(mk(TABLE_OP, 5'h11, 5'h00, 8'h00, 16'h0000));
    chk("table", pm_word(12'h009) >> 8, {8'h0, rdv});
    chk("table lat", 16'h0002, 16'(lat));
    // external space while disabled
    s0 = strobes;
    st(16'h0300, 8'h5a);
    ld(16'h0300);
    chk("ext off", 16'h0000, {8'h0, rdv});
    chk("ext off strobes", 16'(s0), 16'(strobes));
    // stack pointer loaded before any interrupt
    st(16'h005c, 8'h5f);
    st(16'h005d, 8'h02);
    repeat (3) begin
      en = 8'($urandom_range(255, 1));
      p = 8'($urandom) | (en & (~en + 8'h01));
      st(16'h005b, en);
      st(16'h005f, 8'h80);
      @(posedge clk);
      irq_req <= p;
      seen = 1'b0;
      for (int k = 0; k < 10 && !seen; k++) begin
        @(posedge clk);
        #1;
        seen = (irq_ack === 1'b1);
      end
      irq_req <= 8'h00;
      chk("irq ack", 16'h0001, {15'h0, seen});
      chk("irq vec", {13'h0, lowest(p & en)}, {13'h0, irq_vec});
    end
    // global enable clear blocks all requests
    st(16'h005f, 8'h00);
    @(posedge clk);
    irq_req <= 8'hff;
    seen = 1'b0;
    repeat (10) begin
      @(posedge clk);
      #1;
      seen = seen | (irq_ack === 1'b1);
    end
    irq_req <= 8'h00;
    chk("irq masked", 16'h0000, {15'h0, seen});
    // external bytes and external stack, without and with wait state
    for (int w = 0; w < 2; w++) begin
      pen = w + 1;
      st(16'h005e, w ? 8'hc0 : 8'h80);
      ea = w ? 16'hffff : 16'h0260;
      v = 8'($urandom);
      s0 = strobes;
      st(ea, v);
      chk("ext st lat", 16'(1 + pen), 16'(lat));
      chk("ext busy", 16'h0001, {15'h0, bz});
      ld(ea);
      chk("ext ld", {8'h0, v}, {8'h0, rdv});
      chk("ext ld lat", 16'(1 + pen), 16'(lat));
      chk("ext strobes", 16'(s0 + 2 * pen), 16'(strobes));
      st(16'h005c, 8'h00);
      st(16'h005d, 8'h04);
      c = mk(CALL_OP, 5'h00, 5'h00, 8'h00, 16'h0000);
      c.target = 12'h123;
      run(c);
      chk("call lat", 16'(1 + 2 * pen), 16'(lat));
      c.kind = RET_OP;
      run(c);
      chk("ret lat", 16'(1 + 2 * pen), 16'(lat));
    end
    end_sim();
  end
endmodule
`default_nettype wire

// ===== sim/ext_sram_model.sv
// behavioural external data sram on the core's external bus
`default_nettype none
module ext_sram_model import cpu_store_pkg::*; (
  // clock
  input wire logic clk,
  // bus from the core
  input wire cpu_store_pkg::ext_bus_s ext,
  output logic [7:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:1023];
  logic [7:0] last_ff;
  // store a byte while the write strobe is low and the core drives data
  always @(posedge clk) begin
    if (ext.wr_n === 1'b0 && ext.dout_en === 1'b1) begin
      mem[ext.addr[9:0]] <= ext.dout;
    end
    if (ext.rd_n === 1'b0) begin
      last_ff <= mem[ext.addr[9:0]];
    end
  end
  // released data lines show the inverse of the last byte, never a stale copy
  always_comb begin
    if (ext.rd_n === 1'b0) begin
      ext_rdata = mem[ext.addr[9:0]];
    end else begin
      ext_rdata = ~last_ff;
    end
  end
  initial last_ff = 8'h00;
endmodule
`default_nettype wire

// ===== verilog/cpu_store_core.sv
// register file, data-space decode, fetch pipeline, stack and interrupt order
`default_nettype none
// How it works
// - 32 byte registers, read-operate-write in one cycle
// - top six registers form three 16-bit pointers
// - Z pointer addresses program-memory table reads
// - registers answer at data addresses 0 to 31
// - 64 I/O bytes, direct or after registers
// - next word fetched while current one executes
// - 12-bit program counter over 4096 words
// - return address pushed via 16-bit stack pointer
// - lowest pending vector is served first
// - global enable bit gates every interrupt
// - immediate forms reach only upper sixteen registers
// - any pointer can index any register
// - pointers offer pre-decrement, post-increment; only Y and Z add displacement
// - alu does arithmetic, logic and bit operations
// - 96 register/I-O plus 512 sram addresses
// - external sram follows internal up to top
// - external access only with enable bit set
// - strobes idle during internal accesses
// - one extra cycle per external byte
// - external stack adds two cycles per call
// - wait state doubles those extra cycles
module cpu_store_core #(
  parameter int IRQ_N = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // execution requests
  input wire logic cmd_valid,
  input wire cpu_store_pkg::cmd_s cmd,
  input wire logic [IRQ_N-1:0] irq_req,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  // program memory fetch
  output logic [11:0] pm_addr,
  input wire logic [15:0] pm_data,
  output logic [15:0] instr,
  output logic instr_valid,
  // external data sram
  output var cpu_store_pkg::ext_bus_s ext,
  input wire logic [7:0] ext_rdata,
  // interrupt acknowledge
  output logic irq_ack,
  output logic [2:0] irq_vec
);
  import cpu_store_pkg::*;

  if (IRQ_N < 1 || IRQ_N > 8) begin : g_bad_irq_n
    $error("IRQ_N must lie between 1 and 8");
  end

  typedef enum logic [2:0] {S_RUN = 3'b001, S_EXT = 3'b010, S_TABLE = 3'b100} state_e;
  typedef struct packed {
    state_e st;
    logic [NUM_REGS-1:0][7:0] rf;
    logic [IO_SIZE-1:0][7:0] io;
    logic [SRAM_BYTES-1:0][7:0] ram;
    logic [PC_W-1:0] program_counter;
    logic [PC_W-1:0] pm_addr;
    logic [15:0] instr;
    logic ivld;
    logic busy;
    logic done;
    logic [7:0] rdata;
    cmd_kind_e xk;
    logic [4:0] xrd;
    logic [1:0][15:0] xa;
    logic [1:0][7:0] xd;
    logic xw;
    logic bi;
    logic last;
    logic [1:0] cnt;
    ext_bus_s ext;
    logic ack;
    logic [2:0] vec;
  } core_s;

  core_s s_ff;
  core_s nxt_s;
  logic acc;
  logic ext_en;
  logic wait_on;
  logic [1:0] pen;
  logic [15:0] stack_pointer;
  logic stk_ext;
  logic [IRQ_N-1:0] pend;
  logic irq_go;
  logic [2:0] vec;
  logic [4:0] pb;
  logic [15:0] pv;
  logic [15:0] zp;
  logic [15:0] ea;
  logic ea_ext;
  logic [4:0] imm_dst;
  logic [7:0] ea_reg_byte;

  // data-space read: registers, then I/O, then internal sram, zero above
  function automatic logic [7:0] rd8(input logic [15:0] a);
    if (a < IO_BASE) return s_ff.rf[a[4:0]];
    else if (a < SRAM_BASE) return s_ff.io[6'(a - IO_BASE)];
    else if (a < EXT_BASE) return s_ff.ram[9'(a - SRAM_BASE)];
    return 8'h00;
  endfunction

  // shared decode of the request and of the control bytes
  assign acc = cmd_valid && s_ff.st == S_RUN;
  assign ext_en = s_ff.io[IO_MICRO_CONTROL_REG][MCU_EXT_MEM_ENABLE];
  assign wait_on = s_ff.io[IO_MICRO_CONTROL_REG][MCU_WAIT];
  assign pen = wait_on ? PEN_WAIT : PEN_NO_WAIT;
  assign stack_pointer = {s_ff.io[IO_SP_HI], s_ff.io[IO_SP_LO]};
  assign stk_ext = stack_pointer >= EXT_BASE;
  assign pend = irq_req & s_ff.io[IO_IRQ_EN][IRQ_N-1:0];
  assign irq_go = !cmd_valid && s_ff.st == S_RUN && s_ff.io[IO_STATUS][STAT_I] && |pend;
  assign pb = (cmd.ptr == PS_X) ? PTR_X : (cmd.ptr == PS_Y) ? PTR_Y : PTR_Z;
  assign pv = {s_ff.rf[pb + 5'h01], s_ff.rf[pb]};
  assign zp = {s_ff.rf[PTR_Z_HI], s_ff.rf[PTR_Z]};
  assign ea_ext = ea >= EXT_BASE;
  assign imm_dst = {1'b1, cmd.rd[3:0]};
  assign ea_reg_byte = s_ff.rf[ea[4:0]];

  // effective data-space address for each addressing mode
  always_comb begin
    case (cmd.mode)
      AM_DIRECT: ea = cmd.addr;
      AM_IO: ea = IO_BASE + {10'h000, cmd.addr[5:0]};
      AM_DISP: ea = (cmd.ptr == PS_X) ? pv : pv + {10'h000, cmd.disp};
      AM_PREDEC: ea = pv - 16'h0001;
      default: ea = pv;
    endcase
  end

  // lowest pending index wins
  always_comb begin
    vec = 3'h0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        vec = 3'(i);
      end
    end
  end

  // next-state logic of the whole core
  always_comb begin
    logic [1:0][15:0] ga;
    logic [1:0][7:0] gd;
    logic [1:0] we;
    logic xgo;
    logic xhit;
    logic xwr;
    logic xlast;
    logic [4:0] rdx;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [8:0] res;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [PC_W-1:0] tgt;
    ga = '0;
    gd = '0;
    we = 2'h0;
    xgo = 1'b0;
    xhit = 1'b0;
    xwr = 1'b0;
    xlast = 1'b0;
    rdx = cmd.use_imm ? imm_dst : cmd.rd;
    opa = s_ff.rf[rdx];
    opb = cmd.use_imm ? cmd.imm : s_ff.rf[cmd.rr];
    res = 9'h000;
    hi = 8'h00;
    lo = 8'h00;
    tgt = irq_go ? IRQ_VEC_BASE + {9'h000, vec} : cmd.target;
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.ack = 1'b0;
    case (s_ff.st)
      S_RUN: begin
        nxt_s.instr = pm_data;
        nxt_s.ivld = 1'b1;
        nxt_s.program_counter = s_ff.program_counter + 12'h001;
        nxt_s.ext.rd_n = 1'b1;
        nxt_s.ext.wr_n = 1'b1;
        nxt_s.ext.dout_en = 1'b0;
        nxt_s.cnt = 2'(pen - 2'h1);
        nxt_s.bi = 1'b0;
        nxt_s.xk = irq_go ? CALL_OP : cmd.kind;
        nxt_s.xrd = cmd.rd;
        if (acc) begin
          nxt_s.done = 1'b1;
          case (cmd.kind)
            ALU_OP: begin
              case (cmd.op)
                OP_ADD: res = {1'b0, opa} + {1'b0, opb};
                OP_SUB: res = {1'b0, opa} - {1'b0, opb};
                OP_AND: res = {1'b0, opa & opb};
                OP_OR: res = {1'b0, opa | opb};
                OP_XOR: res = {1'b0, opa ^ opb};
                OP_INC: res = {1'b0, 8'(opa + 8'h01)};
                OP_DEC: res = {1'b0, 8'(opa - 8'h01)};
                OP_COM: res = {1'b1, ~opa};
                OP_LSR: res = {opa[0], 1'b0, opa[7:1]};
                OP_BSET: res = {1'b0, opa | (8'h01 << opb[2:0])};
                OP_BCLR: res = {1'b0, opa & ~(8'h01 << opb[2:0])};
                default: res = {1'b0, opb}; // move
              endcase
              nxt_s.rf[rdx] = res[7:0];
              nxt_s.rdata = res[7:0];
              nxt_s.io[IO_STATUS][STAT_Z] = res[7:0] == 8'h00;
              nxt_s.io[IO_STATUS][STAT_C] = res[8];
            end
            LOAD_IMMEDIATE_OP: begin
              nxt_s.rf[imm_dst] = cmd.imm;
              nxt_s.rdata = cmd.imm;
            end
            LOAD_OP, STORE_OP: begin
              // pointer step happens first so a loaded byte wins on overlap
              if (cmd.mode == AM_PREDEC || cmd.mode == AM_POSTINC) begin
                {nxt_s.rf[pb + 5'h01], nxt_s.rf[pb]} = (cmd.mode == AM_PREDEC) ? ea : pv + 16'h0001;
              end
              ga[0] = ea;
              gd[0] = s_ff.rf[cmd.rr];
              xwr = cmd.kind == STORE_OP;
              xhit = ea_ext;
              if (cmd.kind == LOAD_OP && !(ea_ext && ext_en)) begin
                nxt_s.rf[cmd.rd] = rd8(ea);
                nxt_s.rdata = rd8(ea);
              end
            end
            CALL_OP: begin
              xwr = 1'b1;
            end
            RET_OP: begin
              ga[0] = stack_pointer + 16'h0001;
              ga[1] = stack_pointer + 16'h0002;
              xlast = 1'b1;
              xhit = ga[0] >= EXT_BASE;
              hi = rd8(ga[0]);
              lo = rd8(ga[1]);
              {nxt_s.io[IO_SP_HI], nxt_s.io[IO_SP_LO]} = ga[1];
              nxt_s.ivld = 1'b0;
              if (!(xhit && ext_en)) begin
                nxt_s.program_counter = {hi[3:0], lo};
              end
            end
            default: begin
              nxt_s.st = S_TABLE;
              nxt_s.done = 1'b0;
            end
          endcase
        end
        // calls and taken interrupts push the return address
        if ((acc && cmd.kind == CALL_OP) || irq_go) begin
          ga[0] = stack_pointer;
          ga[1] = stack_pointer - 16'h0001;
          gd[0] = s_ff.program_counter[7:0];
          gd[1] = {4'h0, s_ff.program_counter[11:8]};
          xwr = 1'b1;
          xlast = 1'b1;
          xhit = stk_ext;
          {nxt_s.io[IO_SP_HI], nxt_s.io[IO_SP_LO]} = stack_pointer - 16'h0002;
          nxt_s.program_counter = tgt;
          nxt_s.ivld = 1'b0;
        end
        if (irq_go) begin
          nxt_s.io[IO_STATUS][STAT_I] = 1'b0;
          nxt_s.ack = 1'b1;
          nxt_s.vec = vec;
        end
        xgo = xhit && ext_en && (acc || irq_go) && (xwr || cmd.kind == LOAD_OP || cmd.kind == RET_OP);
        if (xgo) begin
          nxt_s.st = S_EXT;
          nxt_s.done = 1'b0;
          nxt_s.xa = ga;
          nxt_s.xd = gd;
          nxt_s.xw = xwr;
          nxt_s.last = xlast;
          nxt_s.ext.addr = ga[0];
          nxt_s.ext.dout = gd[0];
          nxt_s.ext.rd_n = xwr;
          nxt_s.ext.wr_n = !xwr;
          nxt_s.ext.dout_en = xwr;
        end else if (xwr) begin
          we = {xlast, 1'b1};
        end
      end
      S_EXT: begin
        // each external byte holds the strobe for pen cycles
        if (s_ff.cnt != 2'h0) begin
          nxt_s.cnt = s_ff.cnt - 2'h1;
        end else if (!s_ff.bi && s_ff.last) begin
          nxt_s.bi = 1'b1;
          nxt_s.cnt = 2'(pen - 2'h1);
          nxt_s.xd[0] = s_ff.xw ? s_ff.xd[0] : ext_rdata;
          nxt_s.ext.addr = s_ff.xa[1];
          nxt_s.ext.dout = s_ff.xd[1];
        end else begin
          nxt_s.st = S_RUN;
          nxt_s.done = 1'b1;
          nxt_s.ext.rd_n = 1'b1;
          nxt_s.ext.wr_n = 1'b1;
          nxt_s.ext.dout_en = 1'b0;
          if (s_ff.xk == LOAD_OP) begin
            nxt_s.rf[s_ff.xrd] = ext_rdata;
            nxt_s.rdata = ext_rdata;
          end else if (s_ff.xk == RET_OP) begin
            nxt_s.program_counter = {s_ff.xd[0][3:0], ext_rdata};
            nxt_s.ivld = 1'b0;
          end
        end
      end
      default: begin
        // table byte: odd Z picks the high half of the word
        nxt_s.rf[s_ff.xrd] = zp[0] ? pm_data[15:8] : pm_data[7:0];
        nxt_s.rdata = zp[0] ? pm_data[15:8] : pm_data[7:0];
        nxt_s.st = S_RUN;
        nxt_s.done = 1'b1;
      end
    endcase
    // internal write ports, decoded by address range
    for (int p = 0; p < 2; p++) begin
      if (we[p]) begin
        if (ga[p] < IO_BASE) nxt_s.rf[ga[p][4:0]] = gd[p];
        else if (ga[p] < SRAM_BASE) nxt_s.io[6'(ga[p] - IO_BASE)] = gd[p];
        else if (ga[p] < EXT_BASE) nxt_s.ram[9'(ga[p] - SRAM_BASE)] = gd[p];
      end
    end
    nxt_s.pm_addr = (nxt_s.st == S_TABLE) ? zp[12:1] : nxt_s.program_counter;
    nxt_s.busy = nxt_s.st != S_RUN;
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.st <= S_RUN;
      s_ff.ext.rd_n <= 1'b1;
      s_ff.ext.wr_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register
  assign busy = s_ff.busy;
  assign done = s_ff.done;
  assign rdata = s_ff.rdata;
  assign pm_addr = s_ff.pm_addr;
  assign instr = s_ff.instr;
  assign instr_valid = s_ff.ivld;
  assign ext = s_ff.ext;
  assign irq_ack = s_ff.ack;
  assign irq_vec = s_ff.vec;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_int_strobes: assert property (acc && cmd.kind inside {LOAD_OP, STORE_OP} && !ea_ext
    |=> s_ff.ext.rd_n && s_ff.ext.wr_n) else $error("strobe active on internal access");
  chk_ext_load: assert property (acc && cmd.kind == LOAD_OP && ea_ext && ext_en && !wait_on
    |=> !s_ff.done ##1 s_ff.done) else $error("external load not one cycle longer");
  chk_ext_call: assert property (acc && cmd.kind == CALL_OP && stk_ext && ext_en && !wait_on
    |=> !s_ff.done [*2] ##1 s_ff.done) else $error("external stack call not two cycles longer");
  chk_wait_load: assert property (acc && cmd.kind == LOAD_OP && ea_ext && ext_en && wait_on
    |=> !s_ff.done [*2] ##1 s_ff.done) else $error("wait-state load not two cycles longer");
  chk_fetch_step: assert property (s_ff.st == S_RUN && !acc && !irq_go
    |=> s_ff.program_counter == $past(s_ff.program_counter) + 12'h001 && s_ff.ivld)
    else $error("fetch did not advance");
  chk_irq_gate: assert property (s_ff.ack |-> $past(s_ff.io[IO_STATUS][STAT_I])
    && !s_ff.io[IO_STATUS][STAT_I]) else $error("interrupt taken while disabled");
  chk_irq_order: assert property (s_ff.ack |-> ($past(pend) & ~({IRQ_N{1'b1}} << s_ff.vec)) == '0)
    else $error("lower vector was pending");
  chk_ext_off: assert property (s_ff.st == S_RUN && !ext_en
    |=> s_ff.ext.rd_n && s_ff.ext.wr_n) else $error("strobe while external memory disabled");
  chk_imm_upper: assert property (acc && cmd.kind == LOAD_IMMEDIATE_OP
    |=> s_ff.rf[$past(imm_dst)] == $past(cmd.imm)) else $error("immediate load missed upper register");
  chk_reg_map: assert property (acc && cmd.kind == LOAD_OP && ea < IO_BASE
    |=> s_ff.rdata == $past(ea_reg_byte)) else $error("register not seen at its data address");
endmodule
`default_nettype wire

// ===== verilog/cpu_store_pkg.sv
// constants and carrier types for the cpu storage and addressing core
`default_nettype none
package cpu_store_pkg;
  localparam int NUM_REGS = 32;
  localparam int IO_SIZE = 64;
  localparam int SRAM_BYTES = 512;
  localparam int PC_W = 12;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] EXT_BASE = 16'h0260;
  localparam logic [4:0] PTR_X = 5'h1a;
  localparam logic [4:0] PTR_Y = 5'h1c;
  localparam logic [4:0] PTR_Z = 5'h1e;
  localparam logic [4:0] PTR_Z_HI = 5'h1f;
  localparam logic [5:0] IO_IRQ_EN = 6'h3b;
  localparam logic [5:0] IO_SP_LO = 6'h3c;
  localparam logic [5:0] IO_SP_HI = 6'h3d;
  localparam logic [5:0] IO_MICRO_CONTROL_REG = 6'h3e;
  localparam logic [5:0] IO_STATUS = 6'h3f;
  localparam int STAT_C = 0;
  localparam int STAT_Z = 1;
  localparam int STAT_I = 7;
  localparam int MCU_WAIT = 6;
  localparam int MCU_EXT_MEM_ENABLE = 7;
  localparam logic [1:0] PEN_NO_WAIT = 2'h1;
  localparam logic [1:0] PEN_WAIT = 2'h2;
  localparam logic [11:0] IRQ_VEC_BASE = 12'h001;

  typedef enum logic [2:0] {
    ALU_OP, LOAD_IMMEDIATE_OP, LOAD_OP, STORE_OP, CALL_OP, RET_OP, TABLE_OP
  } cmd_kind_e;
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV, OP_INC, OP_DEC, OP_COM, OP_LSR, OP_BSET, OP_BCLR
  } alu_op_e;
  typedef enum logic [2:0] {AM_DIRECT, AM_IO, AM_PLAIN, AM_DISP, AM_PREDEC, AM_POSTINC} addr_mode_e;
  typedef enum logic [1:0] {PS_X, PS_Y, PS_Z} ptr_sel_e;

  typedef struct packed {
    cmd_kind_e kind;
    alu_op_e op;
    logic use_imm;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [7:0] imm;
    ptr_sel_e ptr;
    addr_mode_e mode;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [11:0] target;
  } cmd_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd_n;
    logic wr_n;
    logic dout_en;
    logic [7:0] dout;
  } ext_bus_s;
endpackage
`default_nettype wire
